// *** adcx_map.svh ***
// adcx_map.svh: clock rate, widths and timing counts of the continuous-readout link
// assumes sys_clk at 100 MHz; times are converted to cycles here
`ifndef ADCX_MAP_SVH
`define ADCX_MAP_SVH
`define ADCX_SYS_MHZ      100
`define ADCX_POR_US       1000
`define ADCX_POR_CYC      (`ADCX_POR_US * `ADCX_SYS_MHZ)
`define ADCX_CONV_CYC     2000
`define ADCX_HALF_CYC     8
`define ADCX_FRAME_BITS   32
`define ADCX_CHAN_BITS    8
`define ADCX_RES_BITS     30
`endif

// *** adcx_pkg.sv ***
// adcx_pkg.sv: types shared by both ends of the converter link
// assumes adcx_map.svh is on the include path
`include "adcx_map.svh"
package adcx_pkg;
	typedef enum logic [2:0] {ST_POR, ST_CONV, ST_SLEEP, ST_XFER, ST_EXT} adcx_state_type;
	typedef struct packed {
		adcx_state_type            st;
		logic [16:0]               cnt;
		logic [4:0]                bit_n;
		logic [31:0]               sh;
		logic [7:0]                ain;
		logic                      sck;
		logic                      sck_oe_n;
		logic                      sdo;
		logic [7:0]                chan;
		logic                      chan_v;
		logic                      ext;
		logic                      busy;
		logic [1:0]                sck_s;
		logic [1:0]                sdi_s;
	} adcx_dev_type;
	typedef struct packed {
		logic [4:0]                cnt;
		logic [31:0]               sh;
		logic [31:0]               res;
		logic                      tog;
		logic [1:0]                rs;
		logic                      seen;
		logic [7:0]                chan_w;
	} adcx_lnk_type;
	typedef struct packed {
		logic [7:0]                hold;
		logic                      rtog;
		logic [1:0]                ts;
		logic                      ts_old;
		logic [31:0]               data;
		logic                      valid;
		logic                      sck_oe_n;
		logic                      cs_n;
	} adcx_hsys_type;
endpackage : adcx_pkg

// *** adcx_if.sv ***
// adcx_if.sv: three-wire link with chip select, both parties' pin signals
// assumes the pull-up on the clock pin is resolved here, not in the ends
`timescale 1ns/1ps
`default_nettype none
interface adcx_if;
	logic dev_sck_o;
	logic dev_sck_oe_n;
	logic host_sck_o;
	logic host_sck_oe_n;
	logic sck;
	logic sdo;
	logic sdi;
	logic cs_n;
	// host drive wins, then device drive, else weak pull-up
	assign sck = !host_sck_oe_n ? host_sck_o : (!dev_sck_oe_n ? dev_sck_o : 1'b1);
	modport dev  (output dev_sck_o, output dev_sck_oe_n, input sck, output sdo, input sdi, input cs_n);
	modport host (output host_sck_o, output host_sck_oe_n, input sck, input sdo, output sdi, output cs_n);
endinterface : adcx_if
`default_nettype wire

// *** adcx_dev.sv ***
// adcx_dev.sv: converter end, mode pick at power-on, convert/sleep/transfer loop
// assumes sys_clk is the device oscillator; sdi and sck pin come through two flops
// What this block does
// - clock mode picked once at power-on end
// - power-on lasts about 1 ms
// - pull-up during power-on; high pin selects internal
// - clock and data held high while converting
// - conversion end drives both low, sleep
// - sleep half clock period, then transfer
// - transfer is exactly 32 rising edges
// - data in sampled on the first 8 rising edges
// - next data bit out on falling edge
// - device drives its clock; far side only pulls it low when ext_sel is set
// - far side latches flag first, last bit 32nd
// - after 32nd rise: data high, new conversion
// - chip select may stay low, three wires
`timescale 1ns/1ps
`default_nettype none
module adcx_dev
	import adcx_pkg::*;
#(
	parameter int unsigned POR_CYC  = `ADCX_POR_CYC,
	parameter int unsigned CONV_CYC = `ADCX_CONV_CYC,
	parameter int unsigned HALF_CYC = `ADCX_HALF_CYC
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	adcx_if.dev                              lnk,
	input  wire logic [`ADCX_RES_BITS-1:0]   result_in,
	output var  logic [`ADCX_CHAN_BITS-1:0]  chan_sel,
	output var  logic                        chan_sel_valid,
	output var  logic                        ext_mode,
	output var  logic                        converting
);
	adcx_dev_type q;
	adcx_dev_type d;
	logic         tick;
	logic         rise;
	logic         fall;
	logic         por_done;
	logic         conv_done;
	logic         last_rise;
	logic         chan_slot;
	logic         pin_sck_hi;
	logic         pin_sdi;

	// counter end points cut to their register widths once, here
	localparam logic [16:0] POR_LAST  = 17'(POR_CYC - 1);
	localparam logic [16:0] CONV_LAST = 17'(CONV_CYC - 1);
	localparam logic [16:0] HALF_LAST = 17'(HALF_CYC - 1);
	localparam logic [4:0]  LAST_BIT  = 5'(`ADCX_FRAME_BITS - 1);
	localparam logic [4:0]  CHAN_END  = 5'(`ADCX_CHAN_BITS);

	// ----------------------------------------------------------------
	// edge timing
	// ----------------------------------------------------------------
	// one half period of the serial clock elapsed
	assign tick = (q.cnt == HALF_LAST);
	// sleep end counts as the first rising edge
	assign rise = tick && ((q.st == ST_SLEEP) || (q.st == ST_XFER && !q.sck));
	assign fall = tick && (q.st == ST_XFER) && q.sck;

	// ----------------------------------------------------------------
	// phase decode
	// ----------------------------------------------------------------
	// power-on and conversion windows run out on the shared counter
	assign por_done   = (q.st == ST_POR) && (q.cnt == POR_LAST);
	assign conv_done  = (q.st == ST_CONV) && (q.cnt == CONV_LAST);
	// the rise that ends the frame hands back to the converter
	assign last_rise  = rise && (q.bit_n == LAST_BIT);
	// only the leading rises of a frame carry address bits
	assign chan_slot  = (q.bit_n < CHAN_END);
	// second stage of each pin synchroniser, the only one read
	assign pin_sck_hi = q.sck_s[1];
	assign pin_sdi    = q.sdi_s[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// whole sequencer in one pass over the state copy
	// frame walk, one step every HALF_CYC cycles:
	// sleep entry drops clock and data together
	// first step raises the clock, rise 1, address bit taken
	// falls move the next result bit onto the data line
	// rise 32 ends the frame; data rises a cycle later
	// so a latch on rise 32 still sees the last result bit
	always_comb begin
		d          = q;
		d.chan_v   = 1'b0;
		// two-flop synchronisers on the clock and data-in pins
		d.sck_s[0] = lnk.sck;
		d.sck_s[1] = q.sck_s[0];
		d.sdi_s[0] = lnk.sdi;
		d.sdi_s[1] = q.sdi_s[0];
		// status flag trails the state by one cycle
		d.busy     = (q.st == ST_CONV);
		case (q.st)
			ST_POR: begin
				// released pin floats to the pull-up unless held low
				d.sck_oe_n = 1'b1;
				d.sdo      = 1'b1;
				if (por_done) begin
					d.cnt = '0;
					if (pin_sck_hi) begin
						d.st       = ST_CONV;
						d.sck      = 1'b1;
						d.sck_oe_n = 1'b0;
					end else begin
						d.st  = ST_EXT;
						d.ext = 1'b1;
					end
				end else begin
					d.cnt = q.cnt + 17'd1;
				end
			end
			ST_CONV: begin
				// busy flag shows on both pins
				d.sck = 1'b1;
				d.sdo = 1'b1;
				if (conv_done) begin
					d.st    = ST_SLEEP;
					d.sck   = 1'b0;
					d.sdo   = 1'b0;
					d.sh    = {2'b00, result_in};
					d.cnt   = '0;
					d.bit_n = '0;
					d.ain   = '0;
				end else begin
					d.cnt = q.cnt + 17'd1;
				end
			end
			// clock divider: counter wraps every half period
			ST_SLEEP, ST_XFER: begin
				d.cnt = tick ? 17'd0 : q.cnt + 17'd1;
				if (rise) begin
					d.st    = ST_XFER;
					d.sck   = 1'b1;
					d.bit_n = q.bit_n + 5'd1;
					// only the leading bits carry the channel address
					if (chan_slot) begin
						d.ain = {q.ain[6:0], pin_sdi};
					end
					// data line rises in the first converting cycle, not on this edge
					if (last_rise) begin
						d.st     = ST_CONV;
						d.cnt    = '0;
						d.chan   = q.ain;
						d.chan_v = 1'b1;
					end
				end else if (fall) begin
					d.sck = 1'b0;
					d.sh  = {q.sh[30:0], 1'b0};
					d.sdo = q.sh[30];
				end
			end
			ST_EXT: begin
				// external clock mode is not served; stay quiet
				d.sck_oe_n = 1'b1;
				d.sdo      = 1'b1;
			end
			default: begin
				d.st = ST_POR;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// power-on sequence restarts on reset release
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// pin released to its pull-up, data idles high, counts clear
			q.st       <= ST_POR;
			q.cnt      <= '0;
			q.bit_n    <= '0;
			q.sh       <= '0;
			q.ain      <= '0;
			q.sck      <= 1'b1;
			q.sck_oe_n <= 1'b1;
			q.sdo      <= 1'b1;
			q.chan     <= '0;
			q.chan_v   <= 1'b0;
			q.ext      <= 1'b0;
			q.busy     <= 1'b0;
			q.sck_s    <= '0;
			q.sdi_s    <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// link pins straight from the state register
	assign lnk.dev_sck_o    = q.sck;
	assign lnk.dev_sck_oe_n = q.sck_oe_n;
	assign lnk.sdo          = q.sdo;
	// status toward the system side
	assign chan_sel         = q.chan;
	assign chan_sel_valid   = q.chan_v;
	assign ext_mode         = q.ext;
	assign converting       = q.busy;
endmodule : adcx_dev
`default_nettype wire

// *** adcx_host.sv ***
// adcx_host.sv: controller end, captures 32-bit frames on the device clock
// assumes the device makes sck; frame words cross to sys_clk by toggle handshake
`timescale 1ns/1ps
`default_nettype none
module adcx_host
	import adcx_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	adcx_if.host                             lnk,
	input  wire logic                        ext_sel,
	input  wire logic [`ADCX_CHAN_BITS-1:0]  chan_in,
	input  wire logic                        chan_req,
	output var  logic [`ADCX_FRAME_BITS-1:0] frame_data,
	output var  logic                        frame_valid
);
	adcx_lnk_type  lq;
	adcx_lnk_type  ld;
	adcx_hsys_type sq;
	adcx_hsys_type sd;
	logic          sdi_q;
	logic          last;

	// ----------------------------------------------------------------
	// link side, clocked by the device clock
	// ----------------------------------------------------------------
	assign last = (lq.cnt == 5'(`ADCX_FRAME_BITS - 1));
	// capture one bit per rising edge, flag first, last bit at 32nd
	always_comb begin
		ld       = lq;
		ld.rs[0] = sq.rtog;
		ld.rs[1] = lq.rs[0];
		ld.sh    = {lq.sh[30:0], lnk.sdo};
		ld.cnt   = lq.cnt + 5'd1;
		if (last) begin
			ld.cnt = '0;
			ld.res = {lq.sh[30:0], lnk.sdo};
			ld.tog = ~lq.tog;
			// a new channel only between frames
			if (lq.rs[1] != lq.seen) begin
				ld.chan_w = sq.hold;
				ld.seen   = lq.rs[1];
			end
		end
	end

	// clock stops between frames, so reset acts without it
	always_ff @(posedge lnk.sck or posedge rst) begin
		if (rst)
			lq <= '0;
		else
			lq <= ld;
	end

	// next channel bit ready before each rising edge
	always_ff @(negedge lnk.sck or posedge rst) begin
		if (rst)
			sdi_q <= 1'b0;
		else
			sdi_q <= (lq.cnt < 5'(`ADCX_CHAN_BITS)) ? lq.chan_w[3'(7 - lq.cnt)] : 1'b0;
	end

	// ----------------------------------------------------------------
	// system side
	// ----------------------------------------------------------------
	// frame toggle sync and channel request toggle
	always_comb begin
		sd          = sq;
		sd.ts[0]    = lq.tog;
		sd.ts[1]    = sq.ts[0];
		sd.ts_old   = sq.ts[1];
		sd.valid    = (sq.ts[1] != sq.ts_old);
		sd.cs_n     = 1'b0;
		sd.sck_oe_n = ~ext_sel;
		if (sq.ts[1] != sq.ts_old)
			sd.data = lq.res;
		if (chan_req) begin
			sd.hold = chan_in;
			sd.rtog = ~sq.rtog;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sq          <= '0;
			sq.sck_oe_n <= 1'b1;
		end else begin
			sq <= sd;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign lnk.host_sck_o    = 1'b0;
	assign lnk.host_sck_oe_n = sq.sck_oe_n;
	assign lnk.sdi           = sdi_q;
	assign lnk.cs_n          = sq.cs_n;
	assign frame_data        = sq.data;
	assign frame_valid       = sq.valid;
endmodule : adcx_host
`default_nettype wire

// *** adcx_chk.sv ***
// adcx_chk.sv: assertions on the pins of the continuous-readout link
// assumes one adcx_if joining both ends, half clock period of 8 sys_clk
`timescale 1ns/1ps
`default_nettype none
module adcx_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic dev_sck_oe_n,
	input wire logic host_sck_oe_n,
	input wire logic sck,
	input wire logic sdo,
	input wire logic sdi,
	input wire logic cs_n
);
	logic [7:0] hi_q;
	logic [5:0] rc_q;
	logic       seen_q;
	logic       eoc;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// helper: high run length and rises per frame
	// ----------------------------------------
	assign eoc = !sck && (hi_q > 8'h0A);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hi_q   <= 8'h00;
			rc_q   <= 6'h00;
			seen_q <= 1'b0;
		end else begin
			hi_q <= !sck ? 8'h00 : ((hi_q == 8'hFF) ? hi_q : hi_q + 8'h01);
			if (eoc) begin
				rc_q   <= 6'h00;
				seen_q <= 1'b1;
			end else if (sck && hi_q == 8'h00) begin
				rc_q <= rc_q + 6'h01;
			end
		end
	end
	// ----------------------------------------
	// link properties
	// ----------------------------------------
	a_eoc_both_low: assert property (eoc |-> !sdo && !dev_sck_oe_n)
		else $error("end of conversion without both lines low");
	a_frame_rises: assert property (eoc && seen_q |-> rc_q == 6'h20)
		else $error("frame did not have 32 clock rises");
	a_conv_sdo_high: assert property (sck && hi_q > 8'h0A |-> sdo)
		else $error("data line low during conversion");
	a_sleep_then_clock: assert property (eoc |-> ##[8:9] sck)
		else $error("transfer clock did not start after sleep");
	a_high_half: assert property ($rose(sck) |-> sck[*8])
		else $error("clock high phase too short");
	a_low_half: assert property ($fell(sck) |-> (!sck)[*8])
		else $error("clock low phase too short");
	a_sdo_on_fall: assert property ($changed(sdo) |-> $fell(sck) || (sck && sdo))
		else $error("data out changed off a falling clock");
	a_sdi_when_low: assert property ($changed(sdi) |-> !sck)
		else $error("data in changed while clock high");
	a_dev_drives_sck: assert property ($fell(sck) && host_sck_oe_n |-> !dev_sck_oe_n)
		else $error("clock fell without device drive");
	a_host_hands_off: assert property (!dev_sck_oe_n |-> host_sck_oe_n)
		else $error("controller drives the clock pin");
	a_cs_tied_low: assert property (!$past(rst) |-> !cs_n)
		else $error("chip select not held low");
endmodule : adcx_chk
`default_nettype wire

// *** adc_internal_sck_continuous_readout_test.sv ***
// adc_internal_sck_continuous_readout_test.sv: both link ends back to back, frames scored
// assumes short power-on and conversion counts; the device makes the link clock
`timescale 1ns/1ps
`default_nettype none
module adc_internal_sck_continuous_readout_test;
	import adcx_pkg::*;
	logic        sys_clk;
	logic        rst;
	logic        ext_sel;
	logic        chan_req;
	logic [29:0] result_in;
	logic [7:0]  chan_in;
	logic [7:0]  chan_sel;
	logic        chan_sel_valid;
	logic        ext_mode;
	logic        converting;
	logic        frame_valid;
	logic [31:0] frame_data;
	logic [31:0] qf[$];
	logic [7:0]  qc[$];
	int          n_mismatch;
	int          tests_run;
	int          seed;
	adcx_if adcx_if_inst ();
	adcx_dev #(.POR_CYC(50), .CONV_CYC(40), .HALF_CYC(8)) adcx_dev_inst (.sys_clk(sys_clk), .rst(rst),
		.lnk(adcx_if_inst), .result_in(result_in), .chan_sel(chan_sel), .chan_sel_valid(chan_sel_valid),
		.ext_mode(ext_mode), .converting(converting));
	adcx_host adcx_host_inst (.sys_clk(sys_clk), .rst(rst), .lnk(adcx_if_inst), .ext_sel(ext_sel),
		.chan_in(chan_in), .chan_req(chan_req), .frame_data(frame_data), .frame_valid(frame_valid));
	adcx_chk adcx_chk_inst (.sys_clk(sys_clk), .rst(rst), .dev_sck_oe_n(adcx_if_inst.dev_sck_oe_n),
		.host_sck_oe_n(adcx_if_inst.host_sck_oe_n), .sck(adcx_if_inst.sck), .sdo(adcx_if_inst.sdo),
		.sdi(adcx_if_inst.sdi), .cs_n(adcx_if_inst.cs_n));
	// compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// counts, verdict, end of run
	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	// bounded wait for the start of a conversion
	task automatic wait_conv;
		int   i;
		logic was;
		was = 1'b1;
		for (i = 0; i < 4000; i++) begin
			@(posedge sys_clk);
			#1;
			if (converting === 1'b1 && was === 1'b0) return;
			was = converting;
		end
		n_mismatch++;
		stop_test();
	endtask : wait_conv
	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// watcher: oldest note against each result
	always @(posedge sys_clk) begin
		if (frame_valid === 1'b1) check(frame_data, qf.pop_front());
		if (chan_sel_valid === 1'b1) check({24'h0, chan_sel}, {24'h0, qc.pop_front()});
	end
	// main sequence
	initial begin
		seed = 94766;
		n_mismatch = 0;
		tests_run = 0;
		rst = 1'b1;
		ext_sel = 1'b0;
		chan_req = 1'b0;
		chan_in = 8'h00;
		result_in = 30'h0;
		qc.push_back(8'h00);
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (6) begin
			wait_conv();
			@(posedge sys_clk);
			result_in <= 30'($random(seed));
			chan_in <= 8'($random(seed));
			chan_req <= 1'b1;
			@(posedge sys_clk);
			chan_req <= 1'b0;
			qf.push_back({2'b00, result_in});
			qc.push_back(chan_in);
		end
		wait_conv();
		// let the last frame cross to the system side before counting notes
		repeat (8) @(posedge sys_clk);
		check(qf.size(), 32'h0);
		check(qc.size(), 32'h1);
		check({31'h0, ext_mode}, 32'h0);
		$display("internal clock frames done");
		ext_sel <= 1'b1;
		rst <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (100) @(posedge sys_clk);
		ext_sel <= 1'b0;
		repeat (300) @(posedge sys_clk);
		#1;
		check({29'h0, ext_mode, adcx_if_inst.sdo, converting}, 32'h6);
		$display("external clock pick done");
		stop_test();
	end
endmodule : adc_internal_sck_continuous_readout_test
`default_nettype wire
